//--- alarm_cfg.svh
/*
 * Constants for the channel alarm response and value report block:
 * channel count, condition bit positions, slot size in words, reset values.
 * Assumes inclusion by the package and by design modules.
 */
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

`define NUM_CHAN        8
`define NUM_COND        10
`define SLOT_WORDS      2
`define COND_LOW        0
`define COND_HIGH       1
`define COND_LOWLOW     2
`define COND_HIGHHIGH   3
`define COND_UNDER      4
`define COND_OVER       5
`define COND_OPEN       6
`define COND_CALFLT     7
`define COND_NEGROC     8
`define COND_POSROC     9
`define ENABLE_RST      10'h000
`define UPPER_NEG       16'hffff
`define UPPER_POS       16'h0000

`endif

//--- alarm_pkg.sv
/*
 * Types shared by the alarm response block and its reporting leaf.
 * Assumes alarm_cfg.svh is on the include path.
 */
`include "alarm_cfg.svh"
package alarm_pkg;
    typedef logic [`NUM_COND-1:0]                  cond_vec_t;
    typedef logic [`NUM_CHAN-1:0][`NUM_COND-1:0]   cond_arr_t;
    typedef logic [`NUM_CHAN-1:0][31:0]            word32_arr_t;
    typedef logic [`NUM_CHAN-1:0][15:0]            word16_arr_t;
    typedef enum logic {FMT_FLOAT, FMT_INT16} value_fmt_t;
    typedef enum {SCAN_IDLE, SCAN_LATCH} scan_state_t;
endpackage

//--- value_if.sv
/*
 * Carrier between the top block and its value formatter.
 * Assumes one clock domain.
 */
`timescale 1ns/100ps
`include "alarm_cfg.svh"
interface value_if;
    import alarm_pkg::*;
    word32_arr_t float_val;
    word16_arr_t int_val;
    logic [`NUM_CHAN-1:0] int_fmt;
    word32_arr_t slot;
    modport top (output float_val, output int_val, output int_fmt, input slot);
    modport fmt (input float_val, input int_val, input int_fmt, output slot);
endinterface

//--- value_format.sv
/*
 * Combinational formatting of each channel's two-word value slot.
 * Assumes the caller registers the slot on the input scan.
 */
`timescale 1ns/100ps
`include "alarm_cfg.svh"
module value_format (
    value_if.fmt vif
);
    import alarm_pkg::*;

    function automatic logic [31:0] int_slot(input logic [15:0] v);
        int_slot = {(v[15] ? `UPPER_NEG : `UPPER_POS), v};
    endfunction

    genvar c;
    generate
        for (c = 0; c < `NUM_CHAN; c++) begin : g_ch
            assign vif.slot[c] = vif.int_fmt[c] ? int_slot(vif.int_val[c]) : vif.float_val[c];
        end
    endgenerate
endmodule

//--- alarm_report.sv
/*
 * Per-channel alarm response routing and channel value reporting.
 * Assumes condition, value and scan inputs come from logic on CLK;
 * the controller scans the slots after each SCAN pulse.
 */
`timescale 1ns/100ps
`include "alarm_cfg.svh"
module alarm_report #(
    parameter int NCH = `NUM_CHAN
) (
    input  wire logic                 CLK,
    input  wire logic                 ARST_N,
    input  wire logic                 SCAN,
    input  wire alarm_pkg::cond_arr_t COND,
    input  wire alarm_pkg::cond_arr_t CLEAR_OK,
    input  wire alarm_pkg::cond_arr_t DIAG_EN,
    input  wire alarm_pkg::cond_arr_t FAULT_EN,
    input  wire alarm_pkg::cond_arr_t IRQ_EN,
    input  wire logic [NCH-1:0]       CHAN_EN,
    input  wire logic [NCH-1:0]       FMT_INT,
    input  wire alarm_pkg::word32_arr_t FLOAT_VAL,
    input  wire alarm_pkg::word16_arr_t INT_VAL,
    output alarm_pkg::word32_arr_t    VALUE_SLOT,
    output alarm_pkg::word32_arr_t    DIAG_SLOT,
    output logic                      FAULT_VLD,
    output logic [2:0]                FAULT_CHAN,
    output logic [3:0]                FAULT_COND,
    input  wire logic                 FAULT_RDY,
    output logic [NCH-1:0]            IRQ_REQ
);
    import alarm_pkg::*;

    // fault channel field and slot layout are sized for eight channels
    generate
        if (NCH != `NUM_CHAN) begin : g_bad_nch
            $error("alarm_report serves exactly eight channels");
        end
    endgenerate

    // enables are ports held by configuration; reset state of the block
    // itself holds no enable, so disabled defaults live with the source
    cond_arr_t   status_q, status_d;   // held alarm status
    cond_arr_t   prev_q, prev_d;
    cond_arr_t   irq_diag_q, irq_diag_d;
    cond_arr_t   pend_q, pend_d;
    word32_arr_t vslot_q, vslot_d;
    word32_arr_t dslot_q, dslot_d;
    logic [NCH-1:0] irq_q, irq_d;
    logic        fvld_q, fvld_d;
    logic [2:0]  fch_q, fch_d;
    logic [3:0]  fcd_q, fcd_d;
    value_if     vif ();

    assign vif.float_val = FLOAT_VAL;
    assign vif.int_val   = INT_VAL;
    assign vif.int_fmt   = FMT_INT;

    value_format value_format_inst (.vif(vif));

    // lowest pending channel/condition pair, used for fault entry selection
    function automatic logic [7:0] first_pend(input cond_arr_t p);
        first_pend = 8'h00;
        for (int c = NCH - 1; c >= 0; c--) begin
            for (int k = `NUM_COND - 1; k >= 0; k--) begin
                if (p[c][k]) begin
                    first_pend = {1'b1, c[2:0], k[3:0]};
                end
            end
        end
    endfunction

    logic [7:0] sel;
    assign sel = first_pend(pend_q);

    always_comb begin
        status_d   = status_q;
        prev_d     = prev_q;
        irq_diag_d = irq_diag_q;
        pend_d     = pend_q;
        vslot_d    = vslot_q;
        dslot_d    = dslot_q;
        irq_d      = '0;
        fvld_d     = fvld_q;
        fch_d      = fch_q;
        fcd_d      = fcd_q;
        // fault entry accepted: clear valid; pending bit was dropped when the entry loaded
        if (fvld_q && FAULT_RDY) begin
            fvld_d = 1'b0;
        end
        if (!fvld_d && sel[7]) begin
            fvld_d = 1'b1;
            fch_d  = sel[6:4];
            fcd_d  = sel[3:0];
            pend_d[sel[6:4]][sel[3:0]] = 1'b0;
        end
        if (SCAN) begin
            for (int c = 0; c < NCH; c++) begin
                for (int k = 0; k < `NUM_COND; k++) begin
                    // set on detection, release only outside deadband
                    if (COND[c][k]) begin
                        status_d[c][k] = 1'b1;
                    end else if (CLEAR_OK[c][k]) begin
                        status_d[c][k] = 1'b0;
                    end
                    prev_d[c][k] = status_d[c][k];
                    // one entry per rising occurrence; set wins over drain
                    if (status_d[c][k] && !prev_q[c][k] && FAULT_EN[c][k]) begin
                        pend_d[c][k] = 1'b1;
                    end
                    // interrupt on detection, channel-tied
                    if (COND[c][k] && IRQ_EN[c][k]) begin
                        irq_d[c] = 1'b1;
                    end
                    // interrupt-only bit lasts one scan
                    irq_diag_d[c][k] = COND[c][k] && IRQ_EN[c][k] && !DIAG_EN[c][k];
                end
                // diag bit: enabled and held status, or interrupt-only bit, else zero
                dslot_d[c] = {22'h0,
                              (status_d[c] & DIAG_EN[c]) | irq_diag_d[c]};
                // slot held even for unused channel, reads zero
                vslot_d[c] = CHAN_EN[c] ? vif.slot[c] : 32'h00000000;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            status_q   <= '0;
            prev_q     <= '0;
            irq_diag_q <= '0;
            pend_q     <= '0;
            vslot_q    <= '0;
            dslot_q    <= '0;
            irq_q      <= '0;
            fvld_q     <= 1'b0;
            fch_q      <= 3'h0;
            fcd_q      <= 4'h0;
        end else begin
            status_q   <= status_d;
            prev_q     <= prev_d;
            irq_diag_q <= irq_diag_d;
            pend_q     <= pend_d;
            vslot_q    <= vslot_d;
            dslot_q    <= dslot_d;
            irq_q      <= irq_d;
            fvld_q     <= fvld_d;
            fch_q      <= fch_d;
            fcd_q      <= fcd_d;
        end
    end

    assign VALUE_SLOT = vslot_q;
    assign DIAG_SLOT  = dslot_q;
    assign FAULT_VLD  = fvld_q;
    assign FAULT_CHAN = fch_q;
    assign FAULT_COND = fcd_q;
    assign IRQ_REQ    = irq_q;

    sequence s_int_alarm;
        SCAN && COND[2][`COND_HIGHHIGH] && IRQ_EN[2][`COND_HIGHHIGH]
            && !DIAG_EN[2][`COND_HIGHHIGH];
    endsequence
    // condition gone and outside deadband, so nothing but the interrupt could set it
    sequence s_quiet_scan;
        SCAN && !COND[2][`COND_HIGHHIGH] && CLEAR_OK[2][`COND_HIGHHIGH]
            && !DIAG_EN[2][`COND_HIGHHIGH];
    endsequence

    AST_IRQ_ON_COND: assert property (@(posedge CLK) disable iff (!ARST_N)
        SCAN && |(COND[2] & IRQ_EN[2]) |=> IRQ_REQ[2])
        else $error("interrupt missing after enabled condition");
    AST_IRQ_GATED: assert property (@(posedge CLK) disable iff (!ARST_N)
        !(SCAN && |(COND[2] & IRQ_EN[2])) |=> !IRQ_REQ[2])
        else $error("interrupt without enabled condition");
    AST_IRQ_DIAG_SET: assert property (@(posedge CLK) disable iff (!ARST_N)
        s_int_alarm |=> DIAG_SLOT[2][`COND_HIGHHIGH])
        else $error("interrupt did not set diag bit");
    AST_IRQ_DIAG_CLR: assert property (@(posedge CLK) disable iff (!ARST_N)
        s_int_alarm ##[1:32] s_quiet_scan |=> !DIAG_SLOT[2][`COND_HIGHHIGH])
        else $error("interrupt-only diag bit not cleared");
    AST_DIAG_OFF: assert property (@(posedge CLK) disable iff (!ARST_N)
        SCAN && !DIAG_EN[3][`COND_OVER] && !IRQ_EN[3][`COND_OVER] |=>
            !DIAG_SLOT[3][`COND_OVER])
        else $error("disabled diag bit set");
    AST_DIAG_ON: assert property (@(posedge CLK) disable iff (!ARST_N)
        SCAN && COND[4][`COND_UNDER] && DIAG_EN[4][`COND_UNDER] |=> DIAG_SLOT[4][`COND_UNDER])
        else $error("enabled diag bit not set");
    AST_SIGN_EXT: assert property (@(posedge CLK) disable iff (!ARST_N)
        SCAN && CHAN_EN[1] && FMT_INT[1] |=>
            VALUE_SLOT[1] == {{16{$past(INT_VAL[1][15])}}, $past(INT_VAL[1])})
        else $error("integer slot not sign-extended");
    AST_HOLD: assert property (@(posedge CLK) disable iff (!ARST_N)
        !SCAN |=> $stable(VALUE_SLOT) && $stable(DIAG_SLOT))
        else $error("slots changed outside a scan");
    AST_FAULT_HOLD: assert property (@(posedge CLK) disable iff (!ARST_N)
        FAULT_VLD && !FAULT_RDY |=> FAULT_VLD && $stable(FAULT_CHAN) && $stable(FAULT_COND))
        else $error("fault entry dropped before accept");
    AST_LATCH: assert property (@(posedge CLK) disable iff (!ARST_N)
        status_q[6][`COND_OPEN] && SCAN && !CLEAR_OK[6][`COND_OPEN] |=>
            status_q[6][`COND_OPEN])
        else $error("alarm status released inside deadband");
endmodule

//--- fault_sink.sv
/*
 * Controller model: accepts fault log entries and counts channel interrupts.
 * Assumes one clock and fault fields held until accepted.
 */
`timescale 1ns/100ps
module fault_sink (
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       SLOW,
    input  wire logic       FAULT_VLD,
    input  wire logic [2:0] FAULT_CHAN,
    input  wire logic [3:0] FAULT_COND,
    input  wire logic [7:0] IRQ_REQ,
    output logic            FAULT_RDY
);
    logic [6:0] log_q[$];
    int         irq_cnt[8];
    // slow mode stalls every other cycle so pending entries back up
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FAULT_RDY <= 1'b0;
        end else begin
            FAULT_RDY <= SLOW ? !FAULT_RDY : 1'b1;
            if (FAULT_VLD && FAULT_RDY)
                log_q.push_back({FAULT_CHAN, FAULT_COND});
            // handler bound per channel: one count each
            for (int i = 0; i < 8; i++)
                if (IRQ_REQ[i]) irq_cnt[i]++;
        end
    end
endmodule

//--- channel_alarm_response_and_value_report_test.sv
/*
 * Self-checking bench for alarm_report with a controller model.
 * Assumes the designer's package, interface and modules are compiled first.
 */
`timescale 1ns/100ps
module channel_alarm_response_and_value_report_test;
    import alarm_pkg::*;
    logic        clk, arst_n, scan, slow, fault_vld, fault_rdy;
    cond_arr_t   cond, clear_ok, diag_en, fault_en, irq_en;
    logic [7:0]  chan_en, fmt_int, irq_req;
    word32_arr_t float_val, value_slot, diag_slot;
    word16_arr_t int_val;
    logic [2:0]  fault_chan;
    logic [3:0]  fault_cond;
    int          err_count, tests_run;

    alarm_report alarm_report_inst (.CLK(clk), .ARST_N(arst_n), .SCAN(scan),
        .COND(cond), .CLEAR_OK(clear_ok), .DIAG_EN(diag_en), .FAULT_EN(fault_en),
        .IRQ_EN(irq_en), .CHAN_EN(chan_en), .FMT_INT(fmt_int), .FLOAT_VAL(float_val),
        .INT_VAL(int_val), .VALUE_SLOT(value_slot), .DIAG_SLOT(diag_slot),
        .FAULT_VLD(fault_vld), .FAULT_CHAN(fault_chan), .FAULT_COND(fault_cond),
        .FAULT_RDY(fault_rdy), .IRQ_REQ(irq_req));
    fault_sink fault_sink_inst (.CLK(clk), .ARST_N(arst_n), .SLOW(slow),
        .FAULT_VLD(fault_vld), .FAULT_CHAN(fault_chan), .FAULT_COND(fault_cond),
        .IRQ_REQ(irq_req), .FAULT_RDY(fault_rdy));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // inputs are set before this; slots are settled on return
    task automatic do_scan();
        @(posedge clk);
        #1 scan = 1'b1;
        @(posedge clk);
        #1 scan = 1'b0;
    endtask
    task automatic wait_log(input int n);
        for (int i = 0; i < 40 && fault_sink_inst.log_q.size() < n; i++)
            @(posedge clk);
        if (fault_sink_inst.log_q.size() < n) begin
            err_count++;
            $display("wrong value at %0t: fault entries timed out", $time);
            final_report();
        end
        repeat (8) @(posedge clk);
        chk(fault_sink_inst.log_q.size(), n, "fault entry count");
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        err_count++;
        final_report();
    end
    initial begin
        logic [31:0] exp;
        arst_n = 1'b0;
        scan = 1'b0;
        slow = 1'b0;
        cond = '1;
        clear_ok = '1;
        {diag_en, fault_en, irq_en} = '0;
        chan_en = 8'hff;
        fmt_int = 8'h00;
        float_val = '0;
        int_val = '0;
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        do_scan();
        for (int c = 0; c < 8; c++)
            chk(diag_slot[c], 32'h0, "default diag");
        chk({24'h0, irq_req}, 32'h0, "default irq");
        wait_log(0);
        $display("test defaults done");
        cond = '0;
        diag_en = '1;
        for (int k = 0; k < 10; k++)
            cond[k % 8][k] = 1'b1;
        do_scan();
        for (int c = 0; c < 8; c++) begin
            exp = (32'h1 << c) | ((c < 2) ? (32'h100 << c) : 32'h0);
            chk(diag_slot[c], exp, "diag slot");
        end
        chk({24'h0, irq_req}, 32'h0, "irq off");
        clear_ok = '0;
        cond = '0;
        do_scan();
        chk(diag_slot[7], 32'h80, "held in deadband");
        clear_ok = '1;
        do_scan();
        chk(diag_slot[7], 32'h0, "cleared");
        $display("test diag done");
        diag_en = '0;
        irq_en[2][3] = 1'b1;
        fault_en[2][3] = 1'b1;
        cond[2][3] = 1'b1;
        cond[4][3] = 1'b1;
        do_scan();
        chk({24'h0, irq_req}, 32'h4, "irq ch2");
        chk(diag_slot[2], 32'h8, "irq-only diag");
        chk(diag_slot[4], 32'h0, "no enable");
        cond[2][3] = 1'b0;
        do_scan();
        chk(diag_slot[2], 32'h0, "irq diag cleared");
        chk({24'h0, irq_req}, 32'h0, "no repeat irq");
        wait_log(1);
        chk(fault_sink_inst.log_q[0], {3'd2, 4'd3}, "entry 0");
        cond[2][3] = 1'b0;
        do_scan();
        cond[2][3] = 1'b1;
        do_scan();
        wait_log(2);
        chk(fault_sink_inst.irq_cnt[2], 2, "irq count");
        $display("test irq and fault done");
        slow = 1'b1;
        {fault_en, irq_en, cond} = '0;
        do_scan();
        fault_en[5][0] = 1'b1;
        fault_en[1][9] = 1'b1;
        cond[5][0] = 1'b1;
        cond[1][9] = 1'b1;
        do_scan();
        wait_log(4);
        chk(fault_sink_inst.log_q[2], {3'd1, 4'd9}, "order 1");
        chk(fault_sink_inst.log_q[3], {3'd5, 4'd0}, "order 2");
        $display("test fault order done");
        chan_en = 8'hf7;
        fmt_int = 8'h0e;
        float_val[0] = 32'h3f800000;
        int_val[1] = 16'h8001;
        int_val[2] = 16'h7fff;
        int_val[3] = 16'h1234;
        do_scan();
        chk(value_slot[0], 32'h3f800000, "float");
        chk(value_slot[1], 32'hffff8001, "neg int");
        chk(value_slot[2], 32'h00007fff, "pos int");
        chk(value_slot[3], 32'h0, "unused slot");
        float_val[0] = 32'hc0000000;
        repeat (3) @(posedge clk);
        chk(value_slot[0], 32'h3f800000, "between scans");
        do_scan();
        chk(value_slot[0], 32'hc0000000, "next scan");
        $display("test values done");
        final_report();
    end
endmodule
